// ==== src/crom_device.sv ====
// CAN receive message objects with acceptance, storage, auto-reply and monitor mode
`timescale 1ns/1ps
`default_nettype none
module crom_device #(
  parameter int NOBJ = crom_pkg::NUM_OBJ
) (
  input  wire logic        ref_clk,    // 20 MHz clock
  input  wire logic        nrst,       // Async reset, active low
  crom_if.dev              hp,         // Host register port
  input  wire logic        rxValid,    // Received frame, one-cycle pulse
  input  wire logic        rxRemote,   // Received frame is remote
  input  wire logic [10:0] rxId,       // Received identifier
  input  wire logic [3:0]  rxDlc,      // Received length code
  input  wire logic [63:0] rxData,     // Received bytes, byte 0 low
  output logic             txValid,    // Transmit request, level
  output logic [3:0]       txObj,      // Object being sent
  output logic [10:0]      txId,       // Transmit identifier
  output logic             txRemote,   // Transmit remote flag
  output logic [3:0]       txDlc,      // Transmit length
  output logic [63:0]      txData,     // Transmit bytes
  input  wire logic        txDone      // Transmission done, one-cycle pulse
);
  typedef struct packed {
    logic [NOBJ-1:0][10:0] id;
    logic [NOBJ-1:0]       rtr;
    logic [NOBJ-1:0][3:0]  dlc;
    logic [NOBJ-1:0][63:0] data;
    logic [63:0]           shadow;
    logic [15:0]           ready;
    logic [15:0]           rim;
    logic [15:0]           rpend;
    logic [15:0]           txReq;
    logic [15:0]           txAuto;
    logic                  monEn;
    logic [7:0]            ints;
    logic [7:0]            interrupt_mask_register;
    logic [7:0]            rdata;
    logic                  ack;
    logic                  txValid;
    logic [3:0]            txObj;
    logic [10:0]           txId;
    logic                  txRemote;
    logic [3:0]            txDlc;
    logic [63:0]           txData;
  } crom_dev_st_t;

  crom_dev_st_t st_q, st_d;

  // Highest-numbered object accepting this frame; index 0 skipped when skip0 (monitor mode) is set
  function automatic logic [4:0] find_match(input crom_dev_st_t s, input logic [10:0] id,
                                            input logic remote, input logic skip0);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 0; i < NOBJ; i++) begin
      if (s.id[i] == id && !(skip0 && i == 0)) begin
        if (remote || !s.rtr[i]) begin
          r = 5'(i);
        end
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] top_bit(input logic [15:0] v);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 0; i < 16; i++) begin
      if (v[i]) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  logic [4:0] hit;
  logic [4:0] txSel;
  logic [3:0] obj;
  logic [2:0] byteSel;
  logic       irqOut;

  assign hit     = find_match(st_q, rxId, rxRemote, st_q.monEn);
  assign txSel   = top_bit(st_q.txReq);
  assign obj     = hp.addr[6:3];
  assign byteSel = hp.addr[2:0];

  always_comb begin
    st_d     = st_q;
    st_d.ack = 1'b0;
    // Scheduler first, so a new request in the done cycle is kept
    if (!st_q.txValid && txSel != 5'h10) begin
      st_d.txValid  = 1'b1;
      st_d.txObj    = txSel[3:0];
      st_d.txId     = st_q.id[txSel[3:0]];
      st_d.txRemote = st_q.rtr[txSel[3:0]] && !st_q.txAuto[txSel[3:0]];
      st_d.txDlc    = st_q.dlc[txSel[3:0]];
      st_d.txData   = st_q.data[txSel[3:0]];
    end else if (st_q.txValid && txDone) begin
      st_d.txValid = 1'b0;
      st_d.txReq[st_q.txObj]  = 1'b0;
      st_d.txAuto[st_q.txObj] = 1'b0;
    end
    if (rxValid) begin
      if (hit != 5'h10) begin
        if (rxRemote && st_q.rtr[hit[3:0]]) begin
          st_d.txReq[hit[3:0]]  = 1'b1;
          st_d.txAuto[hit[3:0]] = 1'b1;
        end else if (!rxRemote) begin
          st_d.data[hit[3:0]]  = rxData;
          st_d.dlc[hit[3:0]]   = rxDlc;
          st_d.ready[hit[3:0]] = 1'b1;
          st_d.ints[crom_pkg::RX_IRQ_POS] = 1'b1;
        end
      end else if (st_q.monEn) begin
        st_d.id[crom_pkg::MON_OBJ]    = rxId;
        st_d.ready[crom_pkg::MON_OBJ] = 1'b1;
        st_d.ints[crom_pkg::RX_IRQ_POS] = 1'b1;
        if (rxRemote) begin
          st_d.dlc[crom_pkg::MON_OBJ] = crom_pkg::DLC_REMOTE;
          st_d.rtr[crom_pkg::MON_OBJ] = 1'b1;
        end else begin
          st_d.dlc[crom_pkg::MON_OBJ]  = rxDlc;
          st_d.data[crom_pkg::MON_OBJ] = rxData;
          st_d.rtr[crom_pkg::MON_OBJ]  = 1'b0;
        end
      end
    end
    if (hp.req) begin
      st_d.ack   = 1'b1;
      st_d.rdata = 8'h00;
      if (hp.addr >= crom_pkg::DREG_DATA) begin
        if (hp.wr) begin
          st_d.shadow[8*byteSel +: 8] = hp.wdata;
          if (byteSel == 3'h0) begin
            st_d.data[obj] = {st_q.shadow[63:8], hp.wdata};
          end
        end else begin
          st_d.shadow = st_q.data[obj];
          st_d.rdata  = st_q.data[obj][8*byteSel +: 8];
        end
      end else if (hp.addr >= crom_pkg::DREG_DESC) begin
        if (hp.wr && !hp.addr[0]) begin
          st_d.id[hp.addr[4:1]][7:0] = hp.wdata;
        end else if (hp.wr) begin
          st_d.id[hp.addr[4:1]][10:8] = hp.wdata[7:5];
          st_d.rtr[hp.addr[4:1]]      = hp.wdata[4];
          st_d.dlc[hp.addr[4:1]]      = hp.wdata[3:0];
        end else if (!hp.addr[0]) begin
          st_d.rdata = st_q.id[hp.addr[4:1]][7:0];
        end else begin
          st_d.rdata = {st_q.id[hp.addr[4:1]][10:8], st_q.rtr[hp.addr[4:1]], st_q.dlc[hp.addr[4:1]]};
        end
      end else if (hp.addr == crom_pkg::DREG_CTRL) begin
        if (hp.wr) st_d.monEn = hp.wdata[crom_pkg::MON_EN_POS];
        st_d.rdata = {7'h00, st_q.monEn};
      end else if (hp.addr == crom_pkg::DREG_INT) begin
        st_d.rdata = st_q.ints;
      end else if (hp.addr == crom_pkg::DREG_INTERRUPT_MASK_REGISTER) begin
        if (hp.wr) st_d.interrupt_mask_register = hp.wdata;
        st_d.rdata = st_q.interrupt_mask_register;
      end else if (hp.addr == crom_pkg::DREG_RRLO || hp.addr == crom_pkg::DREG_RRHI) begin
        if (hp.wr && hp.addr == crom_pkg::DREG_RRLO) begin
          st_d.ready[7:0] = st_d.ready[7:0] & (hp.wdata | (st_d.ready[7:0] & ~st_q.ready[7:0]));
        end else if (hp.wr) begin
          st_d.ready[15:8] = st_d.ready[15:8] & (hp.wdata | (st_d.ready[15:8] & ~st_q.ready[15:8]));
        end
        st_d.rdata = (hp.addr == crom_pkg::DREG_RRLO) ? st_q.ready[7:0] : st_q.ready[15:8];
      end else if (hp.addr == crom_pkg::DREG_RIMLO) begin
        if (hp.wr) st_d.rim[7:0] = hp.wdata;
        st_d.rdata = st_q.rim[7:0];
      end else if (hp.addr == crom_pkg::DREG_RIMHI) begin
        if (hp.wr) st_d.rim[15:8] = hp.wdata;
        st_d.rdata = st_q.rim[15:8];
      end else if (hp.addr == crom_pkg::DREG_RPLO) begin
        st_d.rdata = st_q.rpend[7:0];
      end else if (hp.addr == crom_pkg::DREG_RPHI) begin
        st_d.rdata = st_q.rpend[15:8];
      end else if (hp.addr == crom_pkg::DREG_TXLO) begin
        if (hp.wr) st_d.txReq[7:0] = st_d.txReq[7:0] | hp.wdata;
        st_d.rdata = st_q.txReq[7:0];
      end else if (hp.addr == crom_pkg::DREG_TXHI) begin
        if (hp.wr) st_d.txReq[15:8] = st_d.txReq[15:8] | hp.wdata;
        st_d.rdata = st_q.txReq[15:8];
      end
    end
    if (st_d.ready == 16'h0000) begin
      st_d.ints[crom_pkg::RX_IRQ_POS] = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Per-object mask and global enable both gate the line
  assign irqOut   = st_q.interrupt_mask_register[crom_pkg::RX_IRQ_EN_POS] && |(st_q.ready & st_q.rim);
  assign hp.irq   = irqOut;
  assign hp.ack   = st_q.ack;
  assign hp.rdata = st_q.rdata;
  assign txValid  = st_q.txValid;
  assign txObj    = st_q.txObj;
  assign txId     = st_q.txId;
  assign txRemote = st_q.txRemote;
  assign txDlc    = st_q.txDlc;
  assign txData   = st_q.txData;
endmodule
`default_nettype wire

// ==== pkg/crom_pkg.sv ====
// Shared constants for the CAN receive-object monitor pair
package crom_pkg;
  localparam int          NUM_OBJ       = 16;
  localparam int          ID_W          = 11;
  localparam int          ADDR_W        = 4;
  localparam logic [3:0]  DLC_REMOTE    = 4'h0;
  localparam logic [7:0]  RX_IRQ_BIT    = 8'h01;
  localparam int          RX_IRQ_POS    = 0;
  localparam int          MON_EN_POS    = 0;
  localparam int          RX_IRQ_EN_POS = 0;
  localparam int          MON_OBJ       = 0;
  // Host-side Avalon register offsets (byte addresses)
  localparam logic [3:0]  HREG_CMD      = 4'h0;
  localparam logic [3:0]  HREG_ADDR     = 4'h4;
  localparam logic [3:0]  HREG_WDATA    = 4'h8;
  localparam logic [3:0]  HREG_STATUS   = 4'hc;
  // Device register map, reached through the device port
  localparam logic [7:0]  DREG_CTRL     = 8'h00;
  localparam logic [7:0]  DREG_INT      = 8'h01;
  localparam logic [7:0]  DREG_INTERRUPT_MASK_REGISTER     = 8'h02;
  localparam logic [7:0]  DREG_RRLO     = 8'h03;
  localparam logic [7:0]  DREG_RRHI     = 8'h04;
  localparam logic [7:0]  DREG_RIMLO    = 8'h05;
  localparam logic [7:0]  DREG_RIMHI    = 8'h06;
  localparam logic [7:0]  DREG_RPLO     = 8'h07;
  localparam logic [7:0]  DREG_RPHI     = 8'h08;
  localparam logic [7:0]  DREG_TXLO     = 8'h09;
  localparam logic [7:0]  DREG_TXHI     = 8'h0a;
  localparam logic [7:0]  DREG_DESC     = 8'h40; // 0x40+2*obj: id low, id high/rtr/dlc
  localparam logic [7:0]  DREG_DATA     = 8'h80; // 0x80+8*obj+byte
  localparam logic [1:0]  INT_RFI_POS   = 2'h1;
endpackage

// ==== pkg/crom_if.sv ====
// Register port between the host controller and the CAN receive-object device
`timescale 1ns/1ps
`default_nettype none
interface crom_if;
  logic       req;   // Access request, one cycle
  logic       wr;    // 1 write, 0 read
  logic [7:0] addr;  // Device register address
  logic [7:0] wdata; // Write data
  logic [7:0] rdata; // Read data, valid with ack
  logic       ack;   // Access done, one cycle
  logic       irq;   // Device interrupt, level
  modport dev  (input req, wr, addr, wdata, output rdata, ack, irq);
  modport host (output req, wr, addr, wdata, input rdata, ack, irq);
endinterface
`default_nettype wire

// ==== src/crom_host.sv ====
// Host controller: Avalon-MM slave that relays accesses onto the device port
`timescale 1ns/1ps
`default_nettype none
module crom_host (
  input  wire logic        ref_clk,           // 20 MHz clock
  input  wire logic        nrst,              // Async reset, active low
  input  wire logic [3:0]  avs_address,       // Byte address
  input  wire logic        avs_read,          // Read strobe
  input  wire logic        avs_write,         // Write strobe
  input  wire logic [31:0] avs_writedata,     // Write data
  output logic [31:0]      avs_readdata,      // Read data
  output logic             avs_waitrequest,   // Stall
  output logic             irqSeen,           // Device interrupt, level
  crom_if.host             dp                 // Device register port
);
  typedef enum logic [1:0] {IDLE, ISSUE, WAIT} crom_hst_t;
  typedef struct packed {
    crom_hst_t   state;
    logic        wr;
    logic [7:0]  addr;
    logic [7:0]  wdata;
    logic [7:0]  last;
    logic        busy;
    logic        done;
    logic [31:0] rdata;
  } crom_host_st_t;

  crom_host_st_t st_q, st_d;

  always_comb begin
    st_d       = st_q;
    st_d.done  = 1'b0;
    case (st_q.state)
      IDLE: begin
        if ((avs_read || avs_write) && !st_q.done) begin
          st_d.done  = 1'b1;
          st_d.rdata = 32'h0000_0000;
          if (avs_address == crom_pkg::HREG_CMD) begin
            if (avs_write) begin
              st_d.wr    = avs_writedata[0];
              st_d.state = ISSUE; // host software orders reads itself
              st_d.busy  = 1'b1;
            end
          end else if (avs_address == crom_pkg::HREG_ADDR) begin
            if (avs_write) st_d.addr = avs_writedata[7:0];
            st_d.rdata = {24'h000000, st_q.addr};
          end else if (avs_address == crom_pkg::HREG_WDATA) begin
            if (avs_write) st_d.wdata = avs_writedata[7:0];
            st_d.rdata = {24'h000000, st_q.wdata};
          end else if (avs_address == crom_pkg::HREG_STATUS) begin
            st_d.rdata = {22'h0, dp.irq, st_q.busy, st_q.last};
          end
        end
      end
      ISSUE: begin
        st_d.state = WAIT;
      end
      WAIT: begin
        if (dp.ack) begin
          if (!st_q.wr) st_d.last = dp.rdata;
          st_d.busy  = 1'b0;
          st_d.state = IDLE;
        end
      end
      default: st_d.state = IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign dp.req          = (st_q.state == ISSUE);
  assign dp.wr           = st_q.wr;
  assign dp.addr         = st_q.addr;
  assign dp.wdata        = st_q.wdata;
  assign avs_readdata    = st_q.rdata;
  assign avs_waitrequest = (avs_read || avs_write) && !st_q.done;
  assign irqSeen         = dp.irq;
endmodule
`default_nettype wire

// ==== bench/crom_props.sv ====
// Concurrent checks on the register port between host controller and device
`timescale 1ns/1ps
`default_nettype none
module crom_props (
  input wire logic       ref_clk, // Clock
  input wire logic       nrst,    // Async reset, active low
  input wire logic       req,     // Access request
  input wire logic       wr,      // Write direction
  input wire logic [7:0] addr,    // Register address
  input wire logic [7:0] wdata,   // Write data
  input wire logic [7:0] rdata,   // Read data
  input wire logic       ack,     // Access done
  input wire logic       irq      // Device interrupt
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_ack_follows_req: assert property (req |=> ack)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (ack |-> $past(req))
    else $error("ack without request");
  a_rdata_holds: assert property (!req |=> $stable(rdata))
    else $error("read data changed without access");
  a_pending_zero: assert property (req && !wr && (addr == crom_pkg::DREG_RPLO ||
    addr == crom_pkg::DREG_RPHI) |=> rdata == 8'h00)
    else $error("remote pending flag set");
  a_no_remote_flag: assert property (req && !wr && addr == crom_pkg::DREG_INT
    |=> !rdata[crom_pkg::INT_RFI_POS])
    else $error("remote frame flag set");
  a_int_with_irq: assert property (req && !wr && addr == crom_pkg::DREG_INT && irq
    |=> rdata[crom_pkg::RX_IRQ_POS])
    else $error("interrupt without receive flag");
  a_irq_needs_enable: assert property (req && wr && addr == crom_pkg::DREG_INTERRUPT_MASK_REGISTER
    && !wdata[0] |=> ##1 !irq)
    else $error("interrupt while receive enable is off");
  c_irq_seen: cover property (irq);
  c_monitor_on: cover property (req && wr && addr == crom_pkg::DREG_CTRL && wdata[0]);
  c_int_read: cover property (req && !wr && addr == crom_pkg::DREG_INT && irq);
endmodule
`default_nettype wire

// ==== bench/can_receive_object_monitor_tb_top.sv ====
// Bench: host controller and device joined, driven over Avalon and the receive port
`timescale 1ns/1ps
`default_nettype none
module can_receive_object_monitor_tb_top;
  logic ref_clk, nrst, avRead, avWrite, avWait, irqSeen, rxValid, rxRemote, txValid, txRemote, txDone;
  logic [3:0] avAddr, rxDlc, txObj, txDlc;
  logic [31:0] avWdata, avRdata, rnd;
  logic [10:0] rxId, txId, mId [16];
  logic [63:0] rxData, txData, mData [16];
  logic [3:0] mDlc [16];
  logic mRtr [16];
  logic [15:0] mRdy, mRim;
  logic mMon, mImsk, rem;
  logic [7:0] q;
  logic [10:0] id;
  int numErrors, checked, hit, expTx;
  crom_if bus ();
  crom_host crom_host_inst (.ref_clk(ref_clk), .nrst(nrst), .avs_address(avAddr), .avs_read(avRead),
    .avs_write(avWrite), .avs_writedata(avWdata), .avs_readdata(avRdata), .avs_waitrequest(avWait),
    .irqSeen(irqSeen), .dp(bus));
  crom_device crom_device_inst (.ref_clk(ref_clk), .nrst(nrst), .hp(bus), .rxValid(rxValid),
    .rxRemote(rxRemote), .rxId(rxId), .rxDlc(rxDlc), .rxData(rxData), .txValid(txValid), .txObj(txObj),
    .txId(txId), .txRemote(txRemote), .txDlc(txDlc), .txData(txData), .txDone(txDone));
  crom_props crom_props_inst (.ref_clk(ref_clk), .nrst(nrst), .req(bus.req), .wr(bus.wr),
    .addr(bus.addr), .wdata(bus.wdata), .rdata(bus.rdata), .ack(bus.ack), .irq(bus.irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic stop_test();
    $display("comparisons %0d, errors %0d", checked, numErrors);
    if (numErrors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic tmo(input int n, input int lim);
    if (n >= lim) begin
      numErrors++;
      stop_test();
    end
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic av(input logic [3:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge ref_clk);
    avAddr <= a;
    avWrite <= w;
    avRead <= !w;
    avWdata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avWait !== 1'b0 && n < 50);
    r = avRdata;
    avWrite <= 1'b0;
    avRead <= 1'b0;
    tmo(n, 50);
  endtask
  task automatic dev(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    int n;
    n = 0;
    av(crom_pkg::HREG_ADDR, 1'b1, {24'h0, a}, r);
    av(crom_pkg::HREG_WDATA, 1'b1, {24'h0, d}, r);
    av(crom_pkg::HREG_CMD, 1'b1, {31'h0, w}, r);
    do begin
      av(crom_pkg::HREG_STATUS, 1'b0, 32'h0, r);
      n++;
    end while (r[8] !== 1'b0 && n < 20);
    tmo(n, 20);
    q = r[7:0];
    if (w && a == crom_pkg::DREG_RRLO) mRdy[7:0] &= d;
    if (w && a == crom_pkg::DREG_RRHI) mRdy[15:8] &= d;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    dev(1'b0, a, 8'h00);
    chk({56'h0, q}, {56'h0, exp});
  endtask
  task automatic txchk(input int m, input logic r);
    int n;
    n = 0;
    while (txValid !== 1'b1 && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
    tmo(n, 20);
    chk({txObj, txId, txRemote, txDlc}, {m[3:0], mId[m], r, mDlc[m]});
    chk(txData, mData[m]);
    txDone <= 1'b1;
    @(posedge ref_clk);
    txDone <= 1'b0;
  endtask
  task automatic frame(input logic [3:0] dlc, input logic [63:0] d);
    hit = -1;
    expTx = -1;
    for (int k = 15; k >= 0; k--)
      if (hit < 0 && mId[k] == id && (rem || !mRtr[k]) && !(mMon && k == 0)) hit = k;
    if (hit < 0 && mMon) begin
      hit = 0;
      mId[0] = id;
      mRtr[0] = rem;
      mDlc[0] = rem ? 4'h0 : dlc;
      if (!rem) mData[0] = d;
      mRdy[0] = 1'b1;
    end else if (hit >= 0 && !rem) begin
      mDlc[hit] = dlc;
      mData[hit] = d;
      mRdy[hit] = 1'b1;
    end else if (hit >= 0 && mRtr[hit]) expTx = hit;
    @(posedge ref_clk);
    rxValid <= 1'b1;
    rxRemote <= rem;
    rxId <= id;
    rxDlc <= dlc;
    rxData <= d;
    @(posedge ref_clk);
    rxValid <= 1'b0;
    if (expTx >= 0) txchk(expTx, 1'b0);
  endtask
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    {nrst, avRead, avWrite, rxValid, rxRemote, txDone, mMon} = 7'h00;
    {avAddr, avWdata, rxId, rxDlc, rxData, mRdy} = '0;
    {numErrors, checked} = '0;
    rnd = 32'h320e;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    for (int k = 0; k < 16; k++) begin
      mId[k] = 11'h100 + k[10:0];
      mRtr[k] = (k == 3);
      mDlc[k] = 4'h8;
      mData[k] = 64'h0;
      dev(1'b1, crom_pkg::DREG_DESC + 8'(2 * k), mId[k][7:0]);
      dev(1'b1, crom_pkg::DREG_DESC + 8'(2 * k + 1), {mId[k][10:8], mRtr[k], mDlc[k]});
    end
    for (int b = 7; b >= 0; b--) begin
      mData[3][8*b +: 8] = 8'h30 + 8'(b);
      dev(1'b1, crom_pkg::DREG_DATA + 8'(24 + b), mData[3][8*b +: 8]);
    end
    for (int i = 0; i < 40; i++) begin
      if (i % 10 == 0) begin
        mMon = i >= 20;
        mImsk = i < 30;
        mRim = (i == 10 || i == 20) ? 16'hfffe : 16'hffff;
        dev(1'b1, crom_pkg::DREG_CTRL, {7'h0, mMon});
        dev(1'b1, crom_pkg::DREG_INTERRUPT_MASK_REGISTER, {7'h0, mImsk});
        dev(1'b1, crom_pkg::DREG_RIMLO, mRim[7:0]);
        dev(1'b1, crom_pkg::DREG_RIMHI, mRim[15:8]);
      end
      rnd = lfsr(rnd);
      rem = rnd[9:8] == 2'h0 || i % 8 == 5;
      id = (i % 8 == 5) ? 11'h103 : rnd[4] ? 11'h100 + 11'(rnd[3:0]) : {3'h5, rnd[15:8]};
      frame({1'b0, rnd[12:10]}, {rnd, lfsr(rnd)});
      rd(crom_pkg::DREG_INT, {7'h0, |mRdy});
      rd(crom_pkg::DREG_RRLO, mRdy[7:0]);
      rd(crom_pkg::DREG_RRHI, mRdy[15:8]);
      chk({63'h0, irqSeen}, {63'h0, mImsk & |(mRdy & mRim)});
      if (hit >= 0) begin
        rd(crom_pkg::DREG_DESC + 8'(2 * hit), mId[hit][7:0]);
        rd(crom_pkg::DREG_DESC + 8'(2 * hit + 1), {mId[hit][10:8], mRtr[hit], mDlc[hit]});
        for (int b = 0; b < 8; b++)
          rd(crom_pkg::DREG_DATA + 8'(8 * hit + b), mData[hit][8*b +: 8]);
        if (rnd[21]) begin
          mData[hit][7:0] = rnd[31:24];
          dev(1'b1, crom_pkg::DREG_DATA + 8'(8 * hit), rnd[31:24]);
          rd(crom_pkg::DREG_DATA + 8'(8 * hit + 7), mData[hit][63:56]);
        end
        if (rnd[20]) dev(1'b1, hit < 8 ? crom_pkg::DREG_RRLO : crom_pkg::DREG_RRHI, ~(8'h01 << hit[2:0]));
      end
      if (i == 25) begin
        dev(1'b1, crom_pkg::DREG_TXLO, 8'h01);
        txchk(0, mRtr[0]);
      end
    end
    rd(crom_pkg::DREG_RPLO, 8'h00);
    rd(crom_pkg::DREG_RPHI, 8'h00);
    stop_test();
  end
endmodule
`default_nettype wire
